// ==== core/sss_pkg.sv ====
// sss_pkg: constants and carriers for frame-sync routing, straps and sync outputs
package sss_pkg;
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int FS8_PERIOD_NS = 125000;
    // register byte addresses
    localparam logic [5:0] A_SRC  = 6'h00;
    localparam logic [5:0] A_FMT  = 6'h04;
    localparam logic [5:0] A_OFQ  = 6'h08;
    localparam logic [5:0] A_STAT = 6'h0C;
    localparam logic [5:0] A_EXP0 = 6'h10;
    localparam int         N_EXP  = 5;
    // responses
    localparam logic [1:0] RESP_OK  = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
    // source field top bits for the paired form 11XX
    localparam logic [1:0] SRC_PAIR = 2'h3;
    // sync source select: force low pair, force high pair, else follow selection
    localparam logic [1:0] SS_LOW  = 2'h1;
    localparam logic [1:0] SS_HIGH = 2'h2;
    // input clock index in ic_sync and the expected-frequency bank
    localparam int IX_CLK3 = 0;
    localparam int IX_CLK4 = 1;
    localparam int IX_CLK5 = 2;
    localparam int IX_CLK6 = 3;
    localparam int IX_CLK9 = 4;
    // strap codes of open pins (pull-ups/pull-downs)
    localparam logic [2:0] O3_OPEN = 3'h3;
    localparam logic [2:0] O6_OPEN = 3'h4;
    // expected frequencies in kHz
    localparam logic [19:0] EXP_8K   = 20'h00008;
    localparam logic [19:0] EXP_1944 = 20'h04BF0;
    localparam logic [19:0] EXP_RST [N_EXP] = '{EXP_8K, EXP_8K, EXP_1944, EXP_1944, EXP_1944};
    // measured sync rate codes
    localparam logic [1:0] R_NONE = 2'h0;
    localparam logic [1:0] R_2K   = 2'h1;
    localparam logic [1:0] R_4K   = 2'h2;
    localparam logic [1:0] R_8K   = 2'h3;
    localparam logic [19:0] CNT_MAX = 20'hFFFFF;
    // status field positions
    localparam int ST_RATE_LSB = 8;
    localparam int ST_SYNC_LSB = 16;

    typedef struct packed {
        logic [1:0] ssel;
        logic [3:0] src2;
        logic [3:0] src;
    } sss_src_t;

    typedef struct packed {
        logic [1:0] sf;
        logic       mf_pul;
        logic       mf_inv;
        logic       fo_pul;
        logic       fo_inv;
    } sss_fmt_t;

    localparam sss_src_t SRC_RST = 10'h000;
    localparam sss_fmt_t FMT_RST = 6'h00;
endpackage : sss_pkg

// ==== core/sss_top.sv ====
// sss_top: frame-sync input routing, strap latch, sync outputs, AXI4-Lite registers
// Operation
// - source not 11XX: pin one is named input's sync
// - source 11XX: pin one pairs clock three/five
// - pin two used only for 11XX: clock four/six
// - shared pin three latched as out3 strap bit0
// - pin three syncs clock nine when second source 11XX
// - sync inputs accept 2, 4 or 8 kHz
// - out3 default from straps, open gives 19.44MHz
// - out6 default from straps, open gives 38.88MHz
// - two-bit field selects out6 signal format
// - 8kHz output default clock, invert/pulse bits
// - 2kHz output default clock, invert/pulse bits
// - clocks three, four expect 8kHz after reset
// - clocks five, six, nine expect 19.44MHz
// - reset puts every circuit at defaults
`timescale 1ns/1ps
`default_nettype none
module sss_top #(
    parameter int FS8_CYC = sss_pkg::FS8_PERIOD_NS / sss_pkg::CLK_PERIOD_NS
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // axi4-lite write
    input  wire logic [5:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [5:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // pins
    input  wire logic        frame_sync_in_one,
    input  wire logic        frame_sync_in_two,
    input  wire logic        frame_sync_in_three,
    input  wire logic [1:0]  out3_freq_straps_hi,
    input  wire logic [2:0]  out6_freq_straps,
    input  wire logic        ref_sel_hi,
    // routed syncs and outputs
    output logic             ext_sync,
    output logic [4:0]       ic_sync,
    output logic [2:0]       out3_freq_sel,
    output logic [2:0]       out6_freq_sel,
    output logic [1:0]       out6_signal_format,
    output logic             frame_sync_out,
    output logic             multiframe_sync_out
);
    localparam logic [19:0] FS8_LEN = 20'(FS8_CYC);
    localparam logic [19:0] FS8_HALF = 20'(FS8_CYC / 2);
    localparam logic [19:0] F8_LO = 20'(FS8_CYC * 3 / 4);
    localparam logic [19:0] F4_LO = 20'(FS8_CYC * 3 / 2);
    localparam logic [19:0] F2_LO = 20'(FS8_CYC * 3);
    localparam logic [19:0] F2_HI = 20'(FS8_CYC * 5);

    function automatic logic [31:0] wm(input logic [31:0] o, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++)
        begin
            if (s[b])
                r[8*b +: 8] = d[8*b +: 8];
        end
        return r;
    endfunction : wm

    // bus and register state
    logic aw_got_reg, aw_got_next, w_got_reg, w_got_next;
    logic [5:0] awa_reg, awa_next;
    logic [31:0] wd_reg, wd_next, rd_reg, rd_next;
    logic [3:0] ws_reg, ws_next;
    logic bv_reg, bv_next, rv_reg, rv_next;
    logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
    sss_pkg::sss_src_t src_reg, src_next;
    sss_pkg::sss_fmt_t fmt_reg, fmt_next;
    logic [2:0] of3_reg, of3_next, of6_reg, of6_next;
    logic [19:0] exp_reg [sss_pkg::N_EXP];
    logic [19:0] exp_next [sss_pkg::N_EXP];
    logic [2:0] strap3_reg, strap3_next, strap6_reg, strap6_next;
    logic cap_reg, cap_next;
    logic [4:0] ic_sync_reg, ic_sync_next;
    logic ext_reg, ext_next;
    logic [1:0] rate [3];
    logic [2:0] sin;
    logic hit;

    assign s_axi_awready = !aw_got_reg && !bv_reg;
    assign s_axi_wready = !w_got_reg && !bv_reg;
    assign s_axi_arready = !rv_reg;
    assign s_axi_bvalid = bv_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rv_reg;
    assign s_axi_rdata = rd_reg;
    assign s_axi_rresp = rresp_reg;

    always_comb
    begin
        aw_got_next = aw_got_reg;
        w_got_next = w_got_reg;
        awa_next = awa_reg;
        wd_next = wd_reg;
        ws_next = ws_reg;
        bv_next = bv_reg;
        bresp_next = bresp_reg;
        rv_next = rv_reg;
        rd_next = rd_reg;
        rresp_next = rresp_reg;
        src_next = src_reg;
        fmt_next = fmt_reg;
        of3_next = of3_reg;
        of6_next = of6_reg;
        exp_next = exp_reg;
        strap3_next = strap3_reg;
        strap6_next = strap6_reg;
        cap_next = 1'b1;
        hit = 1'b0;
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_got_next = 1'b1;
            awa_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_got_next = 1'b1;
            wd_next = s_axi_wdata;
            ws_next = s_axi_wstrb;
        end
        if (bv_reg && s_axi_bready)
            bv_next = 1'b0;
        // write commits one cycle after both halves are held
        if (aw_got_reg && w_got_reg)
        begin
            aw_got_next = 1'b0;
            w_got_next = 1'b0;
            bv_next = 1'b1;
            bresp_next = sss_pkg::RESP_OK;
            for (int i = 0; i < sss_pkg::N_EXP; i++)
            begin
                if (awa_reg == sss_pkg::A_EXP0 + 6'(4 * i))
                begin
                    exp_next[i] = 20'(wm({12'h000, exp_reg[i]}, wd_reg, ws_reg));
                    hit = 1'b1;
                end
            end
            case (awa_reg)
                sss_pkg::A_SRC: src_next = 10'(wm({22'h0, src_reg}, wd_reg, ws_reg));
                sss_pkg::A_FMT: fmt_next = 6'(wm({26'h0, fmt_reg}, wd_reg, ws_reg));
                sss_pkg::A_OFQ:
                begin
                    of3_next = 3'(wm(32'h0, wd_reg, ws_reg));
                    of6_next = 3'(wm(32'h0, wd_reg, ws_reg) >> 4);
                    if (!ws_reg[0])
                    begin
                        of3_next = of3_reg;
                        of6_next = of6_reg;
                    end
                end
                sss_pkg::A_STAT: ;
                default: if (!hit) bresp_next = sss_pkg::RESP_ERR;
            endcase
        end
        if (rv_reg && s_axi_rready)
            rv_next = 1'b0;
        if (s_axi_arvalid && s_axi_arready)
        begin
            rv_next = 1'b1;
            rd_next = 32'h0000_0000;
            rresp_next = sss_pkg::RESP_OK;
            case (s_axi_araddr)
                sss_pkg::A_SRC: rd_next[9:0] = src_reg;
                sss_pkg::A_FMT: rd_next[5:0] = fmt_reg;
                sss_pkg::A_OFQ: rd_next[6:0] = {of6_reg, 1'b0, of3_reg};
                sss_pkg::A_STAT: rd_next = {11'h000, ic_sync_reg, 2'h0, rate[2], rate[1], rate[0],
                                            cap_reg, strap6_reg, 1'b0, strap3_reg};
                default:
                begin
                    rresp_next = sss_pkg::RESP_ERR;
                    for (int i = 0; i < sss_pkg::N_EXP; i++)
                    begin
                        if (s_axi_araddr == sss_pkg::A_EXP0 + 6'(4 * i))
                        begin
                            rd_next = {12'h000, exp_reg[i]};
                            rresp_next = sss_pkg::RESP_OK;
                        end
                    end
                end
            endcase
        end
        // straps sampled in the first cycle after release; outranks a racing write
        if (!cap_reg)
        begin
            strap3_next = {out3_freq_straps_hi, frame_sync_in_three};
            strap6_next = out6_freq_straps;
            of3_next = {out3_freq_straps_hi, frame_sync_in_three};
            of6_next = out6_freq_straps;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            awa_reg <= 6'h00;
            wd_reg <= 32'h0000_0000;
            ws_reg <= 4'h0;
            bv_reg <= 1'b0;
            bresp_reg <= sss_pkg::RESP_OK;
            rv_reg <= 1'b0;
            rd_reg <= 32'h0000_0000;
            rresp_reg <= sss_pkg::RESP_OK;
            src_reg <= sss_pkg::SRC_RST;
            fmt_reg <= sss_pkg::FMT_RST;
            of3_reg <= sss_pkg::O3_OPEN;
            of6_reg <= sss_pkg::O6_OPEN;
            exp_reg <= sss_pkg::EXP_RST;
            strap3_reg <= sss_pkg::O3_OPEN;
            strap6_reg <= sss_pkg::O6_OPEN;
            cap_reg <= 1'b0;
        end
        else
        begin
            aw_got_reg <= aw_got_next;
            w_got_reg <= w_got_next;
            awa_reg <= awa_next;
            wd_reg <= wd_next;
            ws_reg <= ws_next;
            bv_reg <= bv_next;
            bresp_reg <= bresp_next;
            rv_reg <= rv_next;
            rd_reg <= rd_next;
            rresp_reg <= rresp_next;
            src_reg <= src_next;
            fmt_reg <= fmt_next;
            of3_reg <= of3_next;
            of6_reg <= of6_next;
            exp_reg <= exp_next;
            strap3_reg <= strap3_next;
            strap6_reg <= strap6_next;
            cap_reg <= cap_next;
        end
    end

    // sync pin routing
    logic pair1, pair2, use_hi;
    always_comb
    begin
        pair1 = src_reg.src[3:2] == sss_pkg::SRC_PAIR;
        pair2 = src_reg.src2[3:2] == sss_pkg::SRC_PAIR;
        use_hi = (src_reg.ssel == sss_pkg::SS_HIGH) || (src_reg.ssel != sss_pkg::SS_LOW && ref_sel_hi);
        ext_next = !pair1 && frame_sync_in_one;
        ic_sync_next = 5'h00;
        ic_sync_next[sss_pkg::IX_CLK3] = pair1 && !use_hi && frame_sync_in_one;
        ic_sync_next[sss_pkg::IX_CLK5] = pair1 && use_hi && frame_sync_in_one;
        ic_sync_next[sss_pkg::IX_CLK4] = pair1 && !use_hi && frame_sync_in_two;
        ic_sync_next[sss_pkg::IX_CLK6] = pair1 && use_hi && frame_sync_in_two;
        // the shared pin is still a strap until capture is done
        ic_sync_next[sss_pkg::IX_CLK9] = cap_reg && pair2 && frame_sync_in_three;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ext_reg <= 1'b0;
            ic_sync_reg <= 5'h00;
        end
        else
        begin
            ext_reg <= ext_next;
            ic_sync_reg <= ic_sync_next;
        end
    end

    assign ext_sync = ext_reg;
    assign ic_sync = ic_sync_reg;
    assign out3_freq_sel = of3_reg;
    assign out6_freq_sel = of6_reg;
    assign out6_signal_format = fmt_reg.sf;

    // sync rate measurement, one per input pin
    assign sin = {frame_sync_in_three, frame_sync_in_two, frame_sync_in_one};
    for (genvar g = 0; g < 3; g++)
    begin : g_rate
        logic prev_reg, prev_next;
        logic [19:0] per_reg, per_next;
        logic [1:0] rate_reg, rate_next;
        always_comb
        begin
            prev_next = sin[g];
            per_next = (per_reg == sss_pkg::CNT_MAX) ? per_reg : per_reg + 20'h00001;
            rate_next = rate_reg;
            if (sin[g] && !prev_reg)
            begin
                per_next = 20'h00001;
                if (per_reg < F8_LO || per_reg > F2_HI)
                    rate_next = sss_pkg::R_NONE;
                else if (per_reg < F4_LO)
                    rate_next = sss_pkg::R_8K;
                else if (per_reg < F2_LO)
                    rate_next = sss_pkg::R_4K;
                else
                    rate_next = sss_pkg::R_2K;
            end
            else if (per_reg > F2_HI)
                rate_next = sss_pkg::R_NONE;
        end
        always_ff @(posedge clk)
        begin
            if (!rst_n)
            begin
                prev_reg <= 1'b0;
                per_reg <= 20'h00000;
                rate_reg <= sss_pkg::R_NONE;
            end
            else
            begin
                prev_reg <= prev_next;
                per_reg <= per_next;
                rate_reg <= rate_next;
            end
        end
        assign rate[g] = rate_reg;
    end

    // 8kHz and 2kHz sync outputs
    logic [19:0] fs_cnt_reg, fs_cnt_next;
    logic [1:0] mf_q_reg, mf_q_next;
    logic fso_reg, fso_next, mfo_reg, mfo_next;
    always_comb
    begin
        fs_cnt_next = (fs_cnt_reg == FS8_LEN - 20'h00001) ? 20'h00000 : fs_cnt_reg + 20'h00001;
        mf_q_next = (fs_cnt_next == 20'h00000) ? mf_q_reg + 2'h1 : mf_q_reg;
        // pulse form is one master-clock period wide at the frame start
        fso_next = fmt_reg.fo_pul ? (fs_cnt_next == 20'h00000) : (fs_cnt_next < FS8_HALF);
        fso_next = fso_next ^ fmt_reg.fo_inv;
        mfo_next = fmt_reg.mf_pul ? (fs_cnt_next == 20'h00000 && mf_q_next == 2'h0)
                                  : (mf_q_next < 2'h2);
        mfo_next = mfo_next ^ fmt_reg.mf_inv;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            fs_cnt_reg <= 20'h00000;
            mf_q_reg <= 2'h0;
            fso_reg <= 1'b0;
            mfo_reg <= 1'b0;
        end
        else
        begin
            fs_cnt_reg <= fs_cnt_next;
            mf_q_reg <= mf_q_next;
            fso_reg <= fso_next;
            mfo_reg <= mfo_next;
        end
    end

    assign frame_sync_out = fso_reg;
    assign multiframe_sync_out = mfo_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_ext;
        (src_reg.src[3:2] != sss_pkg::SRC_PAIR) && frame_sync_in_one |=> ext_sync;
    endproperty
    a_ext: assert property (p_ext) else $error("pin one not routed as named sync");
    property p_pair1;
        pair1 && frame_sync_in_one |=> (ic_sync[0] ^ ic_sync[2]) && !ext_sync;
    endproperty
    a_pair1: assert property (p_pair1) else $error("pin one not paired");
    property p_pin2;
        !pair1 |=> !ic_sync[1] && !ic_sync[3];
    endproperty
    a_pin2: assert property (p_pin2) else $error("pin two used outside 11XX");
    property p_strap0;
        $rose(cap_reg) |-> strap3_reg[0] == $past(frame_sync_in_three);
    endproperty
    a_strap0: assert property (p_strap0) else $error("strap bit0 not latched");
    property p_ic9;
        ic_sync[4] |-> $past(pair2) && $past(cap_reg);
    endproperty
    a_ic9: assert property (p_ic9) else $error("clock nine sync without 11XX");
    property p_of3;
        $rose(cap_reg) |-> out3_freq_sel == strap3_reg && out6_freq_sel == strap6_reg;
    endproperty
    a_of3: assert property (p_of3) else $error("output defaults not from straps");
    property p_fso;
        // output is held low through reset, so the first edge after release is skipped
        $past(rst_n) && !fmt_reg.fo_pul && $stable(fmt_reg) |-> frame_sync_out == (fmt_reg.fo_inv ^
            ($past(fs_cnt_reg) < FS8_HALF - 20'h00001 || $past(fs_cnt_reg) == FS8_LEN - 20'h00001));
    endproperty
    a_fso: assert property (p_fso) else $error("8kHz default shape wrong");
    property p_mfo;
        !fmt_reg.mf_pul && mf_q_reg == 2'h3 ##1 fmt_reg.mf_inv == $past(fmt_reg.mf_inv) |-> multiframe_sync_out == (fmt_reg.mf_inv ^ (mf_q_reg < 2'h2));
    endproperty
    a_mfo: assert property (p_mfo) else $error("2kHz shape wrong");
    property p_hold;
        cap_reg && $past(cap_reg) |-> $stable(strap3_reg) && $stable(strap6_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("straps changed after capture");
    property p_exp;
        $rose(rst_n) |-> exp_reg[0] == sss_pkg::EXP_8K && exp_reg[4] == sss_pkg::EXP_1944;
    endproperty
    a_exp: assert property (@(posedge clk) p_exp) else $error("expected frequency defaults wrong");

    c_ext: cover property (ext_sync);
    c_ic9: cover property (ic_sync[4]);
    c_8k: cover property (rate[0] == sss_pkg::R_8K);
endmodule : sss_top
`default_nettype wire

// ==== dv/sss_far_end.sv ====
// sss_far_end: frame-sync sources and strap pins facing the block
`timescale 1ns/1ps
`default_nettype none
module sss_far_end (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // stimulus
    input  wire logic [15:0] per [3],
    input  wire logic [2:0]  lvl,
    input  wire logic [2:0]  o3s,
    input  wire logic [2:0]  o6s,
    input  wire logic        sopen,
    // pins
    output logic             frame_sync_in_one,
    output logic             frame_sync_in_two,
    output logic             frame_sync_in_three,
    output logic [1:0]       out3_freq_straps_hi,
    output logic [2:0]       out6_freq_straps
);
    logic [15:0] cnt [3] = '{default: 16'h0000};
    logic [2:0]  pin     = 3'h0;
    logic        rel     = 1'b0;
    logic [2:0]  o3v;
    // open pins settle to their pulls
    assign o3v                 = sopen ? sss_pkg::O3_OPEN : o3s;
    assign out6_freq_straps    = sopen ? sss_pkg::O6_OPEN : o6s;
    assign out3_freq_straps_hi = o3v[2:1];
    // shared pin keeps showing the strap until the capture edge has passed
    assign frame_sync_in_three = rel ? pin[2] : o3v[0];
    assign frame_sync_in_one   = pin[0];
    assign frame_sync_in_two   = pin[1];
    always_ff @(posedge clk)
    begin
        rel <= rst_n;
        for (int i = 0; i < 3; i++)
        begin
            cnt[i] <= (per[i] == 16'h0000 || cnt[i] == per[i] - 16'h0001) ? 16'h0000 : cnt[i] + 16'h0001;
            // one-cycle pulse each period; period zero holds a level
            pin[i] <= (per[i] == 16'h0000) ? lvl[i] : (cnt[i] == 16'h0000);
        end
    end
endmodule : sss_far_end
`default_nettype wire

// ==== dv/testbench.sv ====
// testbench: routing, strap, sync output and register checks of sss_top
`timescale 1ns/1ps
`default_nettype none
module testbench;
    typedef struct packed {
        logic [9:0] src;
        logic       rsel;
        logic [2:0] lvl;
        logic [4:0] mask;
        logic [4:0] ic;
        logic       ext;
    } sss_row_t;
    localparam int FS = 40;
    // {ssel,src2,src}, ref select, pin levels, compared bits, routed syncs, ext sync
    localparam sss_row_t ROWS [9] = '{
        '{10'h005, 1'b0, 3'h7, 5'h1A, 5'h00, 1'b1}, '{10'h00B, 1'b1, 3'h7, 5'h1A, 5'h00, 1'b1},
        '{10'h10C, 1'b1, 3'h3, 5'h1F, 5'h03, 1'b0}, '{10'h20D, 1'b0, 3'h3, 5'h1F, 5'h0C, 1'b0},
        '{10'h00E, 1'b0, 3'h3, 5'h1F, 5'h03, 1'b0}, '{10'h30F, 1'b1, 3'h3, 5'h1F, 5'h0C, 1'b0},
        '{10'h0CC, 1'b0, 3'h5, 5'h1F, 5'h11, 1'b0}, '{10'h08C, 1'b0, 3'h4, 5'h1F, 5'h00, 1'b0},
        '{10'h2FC, 1'b0, 3'h6, 5'h1F, 5'h18, 1'b0}};
    // format field, high cycles of each output over one multiframe
    localparam logic [23:0] FMTS [6] = '{{6'h00, 9'h050, 9'h050}, {6'h12, 9'h004, 9'h050},
        {6'h23, 9'h09C, 9'h050}, {6'h38, 9'h050, 9'h001}, {6'h0C, 9'h050, 9'h09F}, {6'h05, 9'h050, 9'h050}};
    logic        clk, rst_n, ref_sel_hi, sopen, ext_sync, frame_sync_out, multiframe_sync_out;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        frame_sync_in_one, frame_sync_in_two, frame_sync_in_three;
    logic [5:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, out3_freq_straps_hi, out6_signal_format, rsp;
    logic [2:0]  out6_freq_straps, out3_freq_sel, out6_freq_sel, lvl, o3s, o6s;
    logic [4:0]  ic_sync;
    logic [15:0] per [3];
    int          miscompares, checks_done, hi_fs, hi_mf;

    sss_top #(.FS8_CYC(FS)) u_dut (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .frame_sync_in_one, .frame_sync_in_two, .frame_sync_in_three, .out3_freq_straps_hi, .out6_freq_straps,
        .ref_sel_hi, .ext_sync, .ic_sync, .out3_freq_sel, .out6_freq_sel, .out6_signal_format, .frame_sync_out,
        .multiframe_sync_out);
    sss_far_end u_far (.clk, .rst_n, .per, .lvl, .o3s, .o6s, .sopen, .frame_sync_in_one, .frame_sync_in_two,
        .frame_sync_in_three, .out3_freq_straps_hi, .out6_freq_straps);

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        // address and data may be taken at different edges
        do
        begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd_reg(input logic [5:0] a);
        @(posedge clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do
        begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid);
        rd  = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd_reg

    task automatic do_reset;
        rst_n <= 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask : do_reset

    task automatic count_hi;
        hi_fs = 0;
        hi_mf = 0;
        repeat (4 * FS)
        begin
            @(posedge clk);
            hi_fs += int'(frame_sync_out === 1'b1);
            hi_mf += int'(multiframe_sync_out === 1'b1);
        end
    endtask : count_hi

    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : test_done

    initial
    begin
        repeat (20000) @(posedge clk);
        miscompares++;
        test_done();
    end

    initial
    begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, ref_sel_hi} = 6'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 48'h0;
        {lvl, o3s, o6s, sopen} = 10'h001;
        per = '{default: 16'h0000};
        miscompares = 0;
        checks_done = 0;
        rst_n = 1'b0;
        do_reset();
        chk("out3 sel", {29'h0, out3_freq_sel}, 32'h3);
        chk("out6 sel", {29'h0, out6_freq_sel}, 32'h4);
        rd_reg(sss_pkg::A_STAT);
        chk("strap status", rd & 32'hFF, 32'hC3);
        for (int i = 0; i < 5; i++)
        begin
            rd_reg(6'(sss_pkg::A_EXP0 + 6'(4 * i)));
            chk("expected freq", rd, (i < 2) ? 32'h8 : 32'h4BF0);
        end
        rd_reg(6'h24);
        chk("unmapped read", {30'h0, rsp}, 32'h2);
        wr(6'h24, 32'h1, 4'hF);
        chk("unmapped write", {30'h0, rsp}, 32'h2);
        foreach (ROWS[i])
        begin
            lvl        <= ROWS[i].lvl;
            ref_sel_hi <= ROWS[i].rsel;
            wr(sss_pkg::A_SRC, {22'h0, ROWS[i].src}, 4'hF);
            repeat (4) @(posedge clk);
            chk("ext sync", {31'h0, ext_sync}, {31'h0, ROWS[i].ext});
            chk("ic sync", {27'h0, ic_sync & ROWS[i].mask}, {27'h0, ROWS[i].ic});
        end
        foreach (FMTS[i])
        begin
            wr(sss_pkg::A_FMT, {26'h0, FMTS[i][23:18]}, 4'hF);
            rd_reg(sss_pkg::A_FMT);
            chk("fmt reg", rd, {26'h0, FMTS[i][23:18]});
            chk("out6 format", {30'h0, out6_signal_format}, {30'h0, FMTS[i][23:22]});
            repeat (4 * FS) @(posedge clk);
            count_hi();
            chk("frame high", hi_fs, 32'(FMTS[i][17:9]));
            chk("multiframe high", hi_mf, 32'(FMTS[i][8:0]));
        end
        // 8k, 4k and 2k on pins one, two, three
        lvl <= 3'h0;
        per <= '{16'h0028, 16'h0050, 16'h00A0};
        repeat (600) @(posedge clk);
        rd_reg(sss_pkg::A_STAT);
        chk("sync rates", {26'h0, rd[13:8]}, 32'h1B);
        wr(sss_pkg::A_OFQ, 32'h52, 4'hF);
        chk("out3 written", {29'h0, out3_freq_sel}, 32'h2);
        chk("out6 written", {29'h0, out6_freq_sel}, 32'h5);
        wr(sss_pkg::A_OFQ, 32'h77, 4'hE);
        rd_reg(sss_pkg::A_OFQ);
        chk("ofq lane0 off", rd, 32'h52);
        wr(sss_pkg::A_EXP0, 32'hFFFFFFFF, 4'hF);
        rd_reg(sss_pkg::A_EXP0);
        chk("expected width", rd, 32'hFFFFF);
        // second reset mid-run with driven straps
        per   <= '{default: 16'h0000};
        sopen <= 1'b0;
        o3s   <= 3'h4;
        o6s   <= 3'h3;
        do_reset();
        chk("out3 strap", {29'h0, out3_freq_sel}, 32'h4);
        chk("out6 strap", {29'h0, out6_freq_sel}, 32'h3);
        rd_reg(sss_pkg::A_FMT);
        chk("fmt after reset", rd, 32'h0);
        rd_reg(sss_pkg::A_EXP0);
        chk("exp after reset", rd, 32'h8);
        rd_reg(sss_pkg::A_STAT);
        chk("strap status", rd & 32'hFF, 32'hB4);
        // later pin changes must not reach the defaults
        o3s <= 3'h3;
        o6s <= 3'h7;
        repeat (10) @(posedge clk);
        chk("out3 held", {29'h0, out3_freq_sel}, 32'h4);
        rd_reg(sss_pkg::A_OFQ);
        chk("ofq held", rd, 32'h34);
        test_done();
    end
endmodule : testbench
`default_nettype wire
